// ===== fpa_assist_pkg.sv
// constants, field layouts and carrier types for the coprocessor assist
// assumes every user of it imports the whole package
package fpa_assist_pkg;

  localparam int DATA_W = 32;

  // assist request address fields (vector bit = 31 - msb-first bit)
  localparam int SUBSEG_LSB = 24;
  localparam int CMD_LSB    = 8;
  localparam int XF_LSB     = 4;
  localparam int LN_LSB     = 2;
  localparam int ZERO_MSB   = 23;
  localparam int ZERO_LSB   = 5;
  localparam int SEL_LSB    = 1;

  // transfer control codes
  localparam logic [3:0] XF_LOAD  = 4'h0;
  localparam logic [3:0] XF_LEN   = 4'h7;
  localparam logic [3:0] XF_STORE = 4'hF;

  // length field codes
  localparam logic [1:0] LN_NONE = 2'h0;
  localparam logic [1:0] LN_ONE  = 2'h1;
  localparam logic [1:0] LN_TWO  = 2'h2;
  localparam logic [1:0] LN_REG  = 2'h3;

  localparam int         LEN_W     = 6;
  localparam int         CNT_W     = 7;
  localparam logic [6:0] MAX_WORDS = 7'h40;
  localparam logic [5:0] LEN_RST   = 6'h00;
  localparam logic [6:0] W_ONE     = 7'h01;
  localparam logic [6:0] W_TWO     = 7'h02;

  // coprocessor interface register selects (A4..A1)
  localparam logic [3:0] CPR_RESP = 4'h0;
  localparam logic [3:0] CPR_CMD  = 4'h5;
  localparam logic [3:0] CPR_OPND = 4'h8;

  // response codes seen in the upper half of a response read
  localparam logic [15:0] RSP_DONE   = 16'h0802;
  localparam logic [15:0] RSP_BUSY   = 16'h8900;
  localparam logic [15:0] RSP_OP_IN  = 16'h8D00;
  localparam logic [15:0] RSP_OP_OUT = 16'h8E00;

  typedef enum logic [2:0] {
    K_ERR, K_BUSY, K_IN, K_OUT, K_DONE
  } resp_kind_t;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_CMD   = 8'h02,
    S_FETCH = 8'h04,
    S_POLL  = 8'h08,
    S_OPW   = 8'h10,
    S_OPR   = 8'h20,
    S_MEMW  = 8'h40,
    S_PIO   = 8'h80
  } state_t;

  typedef struct packed {
    logic        store;
    logic [31:0] addr;
    logic [31:0] data;
  } req_t;

  typedef struct packed {
    logic        valid;
    logic        exc;
    logic [31:0] data;
  } reply_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  sel;
    logic [31:0] wdata;
  } cp_acc_t;

  localparam cp_acc_t RESP_RD = '{we: 1'b0, sel: CPR_RESP, wdata: 32'h0};

endpackage : fpa_assist_pkg

// ===== op_buffer.sv
// operand buffer: simple dual port memory, registered read data
// assumes write and read on the same clock
`timescale 1ns/1ps
module op_buffer
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 64,
  parameter int AW    = 6
)
(
  input  wire logic             i_clk,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [AW-1:0]    i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW) || WIDTH < 1)
  begin : g_chk
    $error("op_buffer: depth does not fit address width");
  end

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule : op_buffer

// ===== resp_decode.sv
// classifies a coprocessor response word against the transfer plan
// assumes response code sits in the upper half of the read word
`timescale 1ns/1ps
module resp_decode
  import fpa_assist_pkg::*;
(
  input  wire logic [15:0] i_resp,
  input  wire logic        i_dir_in,
  input  wire logic        i_left,
  output resp_kind_t       o_kind
);

  always_comb
  begin
    unique case (i_resp)
      RSP_BUSY:   o_kind = K_BUSY;
      RSP_OP_IN:  o_kind = (i_dir_in && i_left) ? K_IN : K_ERR;
      RSP_OP_OUT: o_kind = (!i_dir_in && i_left) ? K_OUT : K_ERR;
      RSP_DONE:   o_kind = i_left ? K_ERR : K_DONE;
      default:    o_kind = K_ERR;
    endcase
  end

endmodule : resp_decode

// ===== fpa_assist_seq.sv
// coprocessor assist sequencer: pass-through and hardware assist modes
// assumes request, coprocessor and memory ports share i_clk
// Notes on behaviour
// - assist store carries command, transfer, length fields
// - transfer codes 0000, 0111 (needs 11), 1111 only
// - length 00 none, 01 one, 10 two, 11 register
// - length register holds value, readable back
// - length field rules; coprocessor conflict gives exception
// - send command first, then prefetch operands
// - keep polling until coprocessor needs nothing
// - reply on completion, exception reply on problems
// - operand-in reads memory from the address in the store's data
// - poll response until ready for operands
// - one operand register write per word
// - poll until done, then reply
// - software mode only passes accesses through
// - address bits pick register; middle bits zero
// - request data maps straight onto coprocessor data
// - short registers ride on upper half
// - one register per software mode access
// - everything moves through interface registers only
// - six-bit length register, zero means sixty-four
// - assist only when subsegment enable bit set
// - assist burst must be store; data gives address
// - after exception, refuse until status read
`timescale 1ns/1ps
module fpa_assist_seq
  import fpa_assist_pkg::*;
#(
  parameter int BUF_DEPTH = 64
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_req_valid,
  input  req_t             i_req,
  output logic             o_req_ready,
  output reply_t           o_reply,
  input  wire logic [15:0] i_assist_map,
  input  wire logic        i_serial_dis,
  input  wire logic        i_gsr_read,
  output logic             o_serial,
  output logic             o_cp_req,
  output cp_acc_t          o_cp_acc,
  input  wire logic        i_cp_ack,
  input  wire logic [31:0] i_cp_rdata,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic [31:0]      o_mem_addr,
  output logic [31:0]      o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [31:0] i_mem_rdata
);

  localparam int AW = $clog2(BUF_DEPTH);

  if (BUF_DEPTH < 64)
  begin : g_chk
    $error("fpa_assist_seq: buffer must hold sixty-four words");
  end

  logic             rst_meta_r;
  logic             rst_b_s;
  state_t           state_r,    state_nxt;
  req_t             req_r,      req_nxt;
  reply_t           reply_r,    reply_nxt;
  cp_acc_t          cp_acc_r,   cp_acc_nxt;
  logic             cp_req_r,   cp_req_nxt;
  logic             mem_req_r,  mem_req_nxt;
  logic             mem_we_r,   mem_we_nxt;
  logic [31:0]      ea_r,       ea_nxt;
  logic [31:0]      mwd_r,      mwd_nxt;
  logic [15:0]      cmd_r,      cmd_nxt;
  logic             dir_in_r,   dir_in_nxt;
  logic [6:0]       words_r,    words_nxt;
  logic [6:0]       cnt_r,      cnt_nxt;
  logic [5:0]       len_r,      len_nxt;
  logic             serial_r,   serial_nxt;
  logic             ready_r,    ready_nxt;
  logic             fin;
  logic             fin_exc;
  logic [31:0]      fin_data;
  logic             buf_we;
  logic [31:0]      buf_rdata;
  logic             take;
  logic [3:0]       xf;
  logic [1:0]       ln;
  logic [3:0]       sub;
  logic [6:0]       words_of;
  logic [6:0]       cnt_inc;
  logic             len_wr;
  resp_kind_t       kind;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_b_s    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_b_s    <= rst_meta_r;
    end
  end

  assign take    = i_req_valid && ready_r;
  assign sub     = i_req.addr[SUBSEG_LSB +: 4];
  assign xf      = i_req.addr[XF_LSB +: 4];
  assign ln      = i_req.addr[LN_LSB +: 2];
  assign cnt_inc = cnt_r + W_ONE;
  assign words_of = (ln == LN_NONE) ? 7'h00 :
                    (ln == LN_ONE)  ? W_ONE :
                    (ln == LN_TWO)  ? W_TWO :
                    (len_r == LEN_RST) ? MAX_WORDS :
                    {1'b0, len_r};

  resp_decode u_dec
  (
    .i_resp   (i_cp_rdata[31:16]),
    .i_dir_in (dir_in_r),
    .i_left   (cnt_r != words_r),
    .o_kind   (kind)
  );

  op_buffer #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH), .AW(AW)) u_buf
  (
    .i_clk   (i_clk),
    .i_we    (buf_we),
    .i_waddr (cnt_r[AW-1:0]),
    .i_wdata (i_mem_rdata),
    .i_raddr (cnt_nxt[AW-1:0]),
    .o_rdata (buf_rdata)
  );

  always_comb
  begin
    state_nxt   = state_r;
    req_nxt     = req_r;
    reply_nxt   = '0;
    cp_acc_nxt  = cp_acc_r;
    cp_req_nxt  = cp_req_r;
    mem_req_nxt = mem_req_r;
    mem_we_nxt  = mem_we_r;
    ea_nxt      = ea_r;
    mwd_nxt     = mwd_r;
    cmd_nxt     = cmd_r;
    dir_in_nxt  = dir_in_r;
    words_nxt   = words_r;
    cnt_nxt     = cnt_r;
    len_nxt     = len_r;
    serial_nxt  = serial_r;
    fin         = 1'b0;
    fin_exc     = 1'b0;
    fin_data    = 32'h0;
    buf_we      = 1'b0;
    len_wr      = 1'b0;
    unique case (state_r)
      S_IDLE:
      begin
        if (take)
        begin
          req_nxt    = i_req;
          cnt_nxt    = 7'h00;
          ea_nxt     = i_req.data;
          cmd_nxt    = i_req.addr[CMD_LSB +: 16];
          dir_in_nxt = (xf == XF_LOAD);
          words_nxt  = words_of;
          if (serial_r && !i_serial_dis)
          begin
            fin     = 1'b1;
            fin_exc = 1'b1;
          end
          else if (!i_assist_map[sub])
          begin
            if (i_req.addr[ZERO_MSB:ZERO_LSB] != 19'h0)
            begin
              fin     = 1'b1;
              fin_exc = 1'b1;
            end
            else
            begin
              state_nxt  = S_PIO;
              cp_req_nxt = 1'b1;
              cp_acc_nxt = '{we: i_req.store,
                             sel: i_req.addr[SEL_LSB +: 4],
                             wdata: i_req.data};
            end
          end
          else if (xf == XF_LEN)
          begin
            fin     = 1'b1;
            fin_exc = (ln != LN_REG);
            len_wr  = i_req.store && (ln == LN_REG);
            if (len_wr)
            begin
              len_nxt = i_req.data[LEN_W-1:0];
            end
            fin_data = {26'h0, len_r};
          end
          else if ((xf != XF_LOAD && xf != XF_STORE) || !i_req.store)
          begin
            fin     = 1'b1;
            fin_exc = 1'b1;
          end
          else
          begin
            state_nxt  = S_CMD;
            cp_req_nxt = 1'b1;
            cp_acc_nxt = '{we: 1'b1, sel: CPR_CMD,
                           wdata: {i_req.addr[CMD_LSB +: 16], 16'h0000}};
          end
        end
      end
      S_CMD:
      begin
        if (i_cp_ack)
        begin
          cp_req_nxt = 1'b0;
          if (dir_in_r && words_r != 7'h00)
          begin
            state_nxt   = S_FETCH;
            mem_req_nxt = 1'b1;
            mem_we_nxt  = 1'b0;
          end
          else
          begin
            state_nxt  = S_POLL;
            cp_req_nxt = 1'b1;
            cp_acc_nxt = RESP_RD;
          end
        end
      end
      S_FETCH:
      begin
        if (i_mem_ack)
        begin
          buf_we = 1'b1;
          ea_nxt = ea_r + 32'h4;
          if (cnt_inc == words_r)
          begin
            mem_req_nxt = 1'b0;
            cnt_nxt     = 7'h00;
            state_nxt   = S_POLL;
            cp_req_nxt  = 1'b1;
            cp_acc_nxt  = RESP_RD;
          end
          else
          begin
            cnt_nxt = cnt_inc;
          end
        end
      end
      S_POLL:
      begin
        if (i_cp_ack)
        begin
          cp_req_nxt = 1'b0;
          unique case (kind)
            K_BUSY: cp_req_nxt = 1'b1;
            K_IN:   state_nxt  = S_OPW;
            K_OUT:  state_nxt  = S_OPR;
            K_DONE: fin        = 1'b1;
            K_ERR:
            begin
              fin     = 1'b1;
              fin_exc = 1'b1;
            end
          endcase
        end
      end
      S_OPW:
      begin
        if (!cp_req_r)
        begin
          cp_req_nxt = 1'b1;
          cp_acc_nxt = '{we: 1'b1, sel: CPR_OPND, wdata: buf_rdata};
        end
        else if (i_cp_ack)
        begin
          cp_req_nxt = 1'b0;
          cnt_nxt    = cnt_inc;
          if (cnt_inc == words_r)
          begin
            state_nxt  = S_POLL;
            cp_req_nxt = 1'b1;
            cp_acc_nxt = RESP_RD;
          end
        end
      end
      S_OPR:
      begin
        if (!cp_req_r)
        begin
          cp_req_nxt = 1'b1;
          cp_acc_nxt = '{we: 1'b0, sel: CPR_OPND, wdata: 32'h0};
        end
        else if (i_cp_ack)
        begin
          cp_req_nxt  = 1'b0;
          state_nxt   = S_MEMW;
          mem_req_nxt = 1'b1;
          mem_we_nxt  = 1'b1;
          mwd_nxt     = i_cp_rdata;
        end
      end
      S_MEMW:
      begin
        if (i_mem_ack)
        begin
          mem_req_nxt = 1'b0;
          ea_nxt      = ea_r + 32'h4;
          cnt_nxt     = cnt_inc;
          state_nxt   = S_OPR;
          if (cnt_inc == words_r)
          begin
            state_nxt  = S_POLL;
            cp_req_nxt = 1'b1;
            cp_acc_nxt = RESP_RD;
          end
        end
      end
      S_PIO:
      begin
        if (i_cp_ack)
        begin
          fin        = 1'b1;
          fin_data   = i_cp_rdata;
        end
      end
    endcase
    if (fin)
    begin
      state_nxt   = S_IDLE;
      cp_req_nxt  = 1'b0;
      mem_req_nxt = 1'b0;
      reply_nxt   = '{valid: 1'b1, exc: fin_exc, data: fin_data};
    end
    if (fin && fin_exc && !i_serial_dis)
    begin
      serial_nxt = 1'b1;
    end
    else if (i_gsr_read)
    begin
      serial_nxt = 1'b0;
    end
    ready_nxt = (state_nxt == S_IDLE);
  end

  always_ff @(posedge i_clk or negedge rst_b_s)
  begin
    if (!rst_b_s)
    begin
      state_r   <= S_IDLE;
      req_r     <= '0;
      reply_r   <= '0;
      cp_acc_r  <= '0;
      cp_req_r  <= 1'b0;
      mem_req_r <= 1'b0;
      mem_we_r  <= 1'b0;
      ea_r      <= 32'h0;
      mwd_r     <= 32'h0;
      cmd_r     <= 16'h0;
      dir_in_r  <= 1'b0;
      words_r   <= 7'h00;
      cnt_r     <= 7'h00;
      len_r     <= LEN_RST;
      serial_r  <= 1'b0;
      ready_r   <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      req_r     <= req_nxt;
      reply_r   <= reply_nxt;
      cp_acc_r  <= cp_acc_nxt;
      cp_req_r  <= cp_req_nxt;
      mem_req_r <= mem_req_nxt;
      mem_we_r  <= mem_we_nxt;
      ea_r      <= ea_nxt;
      mwd_r     <= mwd_nxt;
      cmd_r     <= cmd_nxt;
      dir_in_r  <= dir_in_nxt;
      words_r   <= words_nxt;
      cnt_r     <= cnt_nxt;
      len_r     <= len_nxt;
      serial_r  <= serial_nxt;
      ready_r   <= ready_nxt;
    end
  end

  assign o_req_ready = ready_r;
  assign o_reply     = reply_r;
  assign o_serial    = serial_r;
  assign o_cp_req    = cp_req_r;
  assign o_cp_acc    = cp_acc_r;
  assign o_mem_req   = mem_req_r;
  assign o_mem_we    = mem_we_r;
  assign o_mem_addr  = ea_r;
  assign o_mem_wdata = mwd_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_b_s);

  a_cmd_forward: assert property (state_r == S_CMD && cp_req_r |->
    cp_acc_r.we && cp_acc_r.sel == CPR_CMD &&
    cp_acc_r.wdata[31:16] == cmd_r)
    else $error("command write does not carry the command field");
  a_bad_code: assert property (take && !serial_r &&
    i_assist_map[sub] && xf != XF_LOAD && xf != XF_STORE &&
    xf != XF_LEN |=> o_reply.valid && o_reply.exc)
    else $error("invalid transfer code not refused");
  a_len_two: assert property (take && !serial_r &&
    i_assist_map[sub] && xf == XF_LOAD && i_req.store &&
    ln == LN_TWO |=> state_r == S_CMD && words_r == W_TWO)
    else $error("two-word length not applied");
  a_len_hold: assert property (!len_wr |=> $stable(len_r))
    else $error("length register changed without a write");
  a_conflict_exc: assert property (state_r == S_POLL &&
    i_cp_ack && cnt_r != words_r && i_cp_rdata[31:16] == RSP_DONE
    |=> o_reply.valid && o_reply.exc)
    else $error("length conflict gave no exception");
  a_fetch_addr: assert property (state_r == S_CMD && i_cp_ack &&
    dir_in_r && words_r != 7'h00 |=> mem_req_r && !mem_we_r &&
    o_mem_addr == req_r.data)
    else $error("prefetch does not start at the effective address");
  a_poll_again: assert property (state_r == S_POLL && i_cp_ack &&
    kind == K_BUSY |=> cp_req_r && !cp_acc_r.we &&
    cp_acc_r.sel == CPR_RESP)
    else $error("busy response not polled again");
  a_opnd_write: assert property (state_r == S_OPW && cp_req_r |->
    cp_acc_r.we && cp_acc_r.sel == CPR_OPND)
    else $error("operand write aimed at wrong register");
  a_pio_select: assert property (state_r == S_PIO && cp_req_r |->
    cp_acc_r.sel == req_r.addr[4:1] && cp_acc_r.we == req_r.store &&
    cp_acc_r.wdata == req_r.data)
    else $error("pass-through access mis-mapped");
  a_serial_block: assert property (take && serial_r &&
    !i_serial_dis |=> o_reply.valid && o_reply.exc ##1 !cp_req_r)
    else $error("serializing state let a request through");

  c_pio_done: cover property (state_r == S_PIO ##1 o_reply.valid);
  c_load_done: cover property (state_r == S_OPW ##[1:200]
    (o_reply.valid && !o_reply.exc));
  c_store_done: cover property (state_r == S_MEMW ##[1:200]
    (o_reply.valid && !o_reply.exc));
  c_exc_reply: cover property (o_reply.valid && o_reply.exc);

endmodule : fpa_assist_seq

// ===== cp_mem_model.sv
// coprocessor interface registers and a memory, far side of the sequencer
// assumes one clock; request held until ack, ack one cycle
`timescale 1ns/1ps
module cp_mem_model
  import fpa_assist_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_cp_req,
  input  cp_acc_t          i_cp_acc,
  output logic             o_cp_ack,
  output logic [31:0]      o_cp_rdata,
  input  wire logic        i_mem_req,
  input  wire logic        i_mem_we,
  input  wire logic [31:0] i_mem_addr,
  input  wire logic [31:0] i_mem_wdata,
  output logic             o_mem_ack,
  output logic [31:0]      o_mem_rdata,
  input  wire logic [6:0]  i_words,
  input  wire logic [1:0]  i_busy,
  input  wire logic        i_slow,
  input  wire logic        i_dir_in,
  output logic [15:0]      o_cmd,
  output logic [6:0]       o_opnd_cnt,
  output logic [31:0]      o_last_opnd,
  output logic [31:0]      o_mem_waddr,
  output logic [31:0]      o_mem_wdat
);
  logic [31:0] regs [16];
  logic [31:0] rd_r;
  logic [31:0] md_r;
  logic [6:0]  left;
  logic [1:0]  bsy;
  logic [1:0]  dly;
  logic        ack_r;
  logic        mack_r;
  logic [15:0] code;

  // released data lines show the inverse of the last value
  assign o_cp_ack    = ack_r;
  assign o_cp_rdata  = ack_r ? rd_r : ~rd_r;
  assign o_mem_ack   = mack_r;
  assign o_mem_rdata = mack_r ? md_r : ~md_r;
  // response script: busy, then operand requests, then done
  assign code = (bsy != 2'h0) ? RSP_BUSY : (left == 7'h00) ? RSP_DONE :
                i_dir_in ? RSP_OP_IN : RSP_OP_OUT;

  always @(posedge i_clk)
  begin
    if (!i_rst_b || !i_cp_req || ack_r)
    begin
      ack_r <= 1'b0;
      dly   <= 2'h0;
    end
    else if (dly < (i_slow ? 2'h3 : 2'h0))
      dly <= dly + 2'h1;
    else
    begin
      ack_r <= 1'b1;
      if (i_cp_acc.we && i_cp_acc.sel == CPR_CMD)
      begin
        o_cmd      <= i_cp_acc.wdata[31:16];
        bsy        <= i_busy;
        left       <= i_words;
        o_opnd_cnt <= 7'h00;
      end
      else if (i_cp_acc.sel == CPR_OPND)
      begin
        o_last_opnd <= i_cp_acc.wdata;
        rd_r        <= 32'hC0DE0000 + {25'h0, o_opnd_cnt};
        o_opnd_cnt  <= o_opnd_cnt + 7'h01;
        if (left != 7'h00)
          left <= left - 7'h01;
      end
      else if (i_cp_acc.we)
        regs[i_cp_acc.sel] <= i_cp_acc.wdata;
      else if (i_cp_acc.sel == CPR_RESP)
      begin
        rd_r <= {code, 16'h0000};
        if (bsy != 2'h0)
          bsy <= bsy - 2'h1;
      end
      else
        rd_r <= regs[i_cp_acc.sel];
    end
  end

  always @(posedge i_clk)
  begin
    mack_r <= i_rst_b && i_mem_req && !mack_r;
    if (i_mem_req && !mack_r)
    begin
      md_r <= ~i_mem_addr;
      if (i_mem_we)
      begin
        o_mem_waddr <= i_mem_addr;
        o_mem_wdat  <= i_mem_wdata;
      end
    end
  end
endmodule : cp_mem_model

// ===== fpa_assist_seq_bench.sv
// self-checking bench for the coprocessor assist sequencer
// assumes cp_mem_model on the far side; subsegment c assists, d passes
`timescale 1ns/1ps
module fpa_assist_seq_bench;
  import fpa_assist_pkg::*;
  localparam logic [15:0] no_operation_command = 16'h0000;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_req_valid = 1'b0;
  req_t        i_req = '0;
  logic [15:0] i_assist_map = 16'h1000;
  logic        i_serial_dis = 1'b0;
  logic        i_gsr_read = 1'b0;
  logic [6:0]  words = 7'h00;
  logic [1:0]  busy = 2'h0;
  logic        slow = 1'b0;
  logic        dir_in = 1'b1;
  logic        o_req_ready, o_serial, o_cp_req, i_cp_ack;
  logic        o_mem_req, o_mem_we, i_mem_ack, exc_r;
  reply_t      o_reply;
  cp_acc_t     o_cp_acc;
  logic [31:0] i_cp_rdata, o_mem_addr, o_mem_wdata, i_mem_rdata, dat_r;
  logic [15:0] cmd;
  logic [6:0]  cnt;
  logic [31:0] last, waddr, wdat;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #50 i_clk = ~i_clk;

  fpa_assist_seq fpa_assist_seq_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_reply(o_reply), .i_assist_map(i_assist_map),
    .i_serial_dis(i_serial_dis), .i_gsr_read(i_gsr_read),
    .o_serial(o_serial), .o_cp_req(o_cp_req), .o_cp_acc(o_cp_acc),
    .i_cp_ack(i_cp_ack), .i_cp_rdata(i_cp_rdata), .o_mem_req(o_mem_req),
    .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata));

  cp_mem_model cp_mem_model_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_cp_req(o_cp_req), .i_cp_acc(o_cp_acc), .o_cp_ack(i_cp_ack),
    .o_cp_rdata(i_cp_rdata), .i_mem_req(o_mem_req), .i_mem_we(o_mem_we),
    .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata),
    .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata), .i_words(words),
    .i_busy(busy), .i_slow(slow), .i_dir_in(dir_in), .o_cmd(cmd),
    .o_opnd_cnt(cnt), .o_last_opnd(last), .o_mem_waddr(waddr),
    .o_mem_wdat(wdat));

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic req(input logic st, input logic [31:0] a,
                     input logic [31:0] d);
    @(negedge i_clk);
    while (o_req_ready !== 1'b1)
      @(negedge i_clk);
    i_req       = '{store: st, addr: a, data: d};
    i_req_valid = 1'b1;
    @(negedge i_clk);
    i_req_valid = 1'b0;
    while (o_reply.valid !== 1'b1)
      @(negedge i_clk);
    exc_r = o_reply.exc;
    dat_r = o_reply.data;
  endtask : req

  task automatic gsr();
    @(negedge i_clk);
    i_gsr_read = 1'b1;
    @(negedge i_clk);
    i_gsr_read = 1'b0;
  endtask : gsr

  task automatic cfg(input logic [6:0] w, input logic [1:0] b,
                     input logic s, input logic di);
    words  = w;
    busy   = b;
    slow   = s;
    dir_in = di;
  endtask : cfg

  function automatic logic [31:0] aa(input logic [15:0] c,
                                     input logic [3:0] t, input logic [1:0] l);
    return {8'h0C, c, t, l, 2'b00};
  endfunction : aa

  function automatic logic [31:0] pa(input logic [3:0] ss,
                                     input logic [3:0] s);
    return {4'h0, ss, 19'h0, s, 1'b0};
  endfunction : pa

  task automatic t_pass(input logic [3:0] ss);
    for (int i = 0; i < 2; i++)
    begin
      cfg(7'h00, 2'h0, i[0], 1'b1);
      req(1'b1, pa(ss, 4'h3 + 4'(i)), 32'hABCD0000 + i);
      chk(exc_r, 1'b0);
      req(1'b0, pa(ss, 4'h3 + 4'(i)), 32'h0);
      chk(dat_r, 32'hABCD0000 + i);
    end
    req(1'b1, pa(ss, 4'h3) | 32'h00000100, 32'h0);
    chk(exc_r, 1'b1);
    gsr();
  endtask : t_pass

  task automatic t_xfer();
    cfg(7'h02, 2'h2, 1'b1, 1'b1);
    req(1'b1, aa(16'h4422, XF_LOAD, LN_TWO), 32'h00001000);
    chk(exc_r, 1'b0);
    chk(cmd, 16'h4422);
    chk(cnt, 7'h02);
    chk(last, ~32'h00001004);
    cfg(7'h02, 2'h1, 1'b0, 1'b0);
    req(1'b1, aa(16'h6801, XF_STORE, LN_TWO), 32'h00002000);
    chk(exc_r, 1'b0);
    chk(waddr, 32'h00002004);
    chk(wdat, 32'hC0DE0001);
    cfg(7'h00, 2'h0, 1'b0, 1'b1);
    req(1'b1, aa(16'h0001, XF_LOAD, LN_NONE), 32'h00003000);
    chk(cnt, 7'h00);
    cfg(7'h02, 2'h0, 1'b0, 1'b1);
    req(1'b1, aa(16'h4422, XF_LOAD, LN_ONE), 32'h00001000);
    chk(exc_r, 1'b1);
    gsr();
    cfg(7'h00, 2'h0, 1'b0, 1'b1);
    req(1'b1, aa(16'h4422, XF_LOAD, LN_ONE), 32'h00001000);
    chk(exc_r, 1'b1);
    gsr();
  endtask : t_xfer

  task automatic t_nop();
    int polls;
    polls = 0;
    cfg(7'h00, 2'h2, 1'b0, 1'b1);
    req(1'b1, pa(4'hD, CPR_CMD), {no_operation_command, 16'h0000});
    chk(cmd, no_operation_command);
    do
    begin
      req(1'b0, pa(4'hD, CPR_RESP), 32'h0);
      polls++;
    end
    while (dat_r[31:16] == RSP_BUSY && polls < 8);
    chk(dat_r[31:16], RSP_DONE);
    chk(polls, 3);
  endtask : t_nop

  task automatic t_len(input logic [5:0] n);
    req(1'b1, aa(16'h0000, XF_LEN, LN_REG), {26'h0, n});
    chk(exc_r, 1'b0);
    req(1'b0, aa(16'h0000, XF_LEN, LN_REG), 32'h0);
    chk(dat_r, {26'h0, n});
    cfg((n == 6'h00) ? 7'h40 : {1'b0, n}, 2'h0, 1'b0, 1'b1);
    req(1'b1, aa(16'h4400, XF_LOAD, LN_REG), 32'h00004000);
    chk(cnt, (n == 6'h00) ? 32'h40 : {26'h0, n});
  endtask : t_len

  task automatic t_refuse();
    for (int t = 1; t < 15; t++)
    begin
      if (t == 7)
        continue;
      req(1'b1, aa(16'h0000, 4'(t), LN_ONE), 32'h0);
      chk(exc_r, 1'b1);
      gsr();
    end
    req(1'b1, aa(16'h0000, XF_LEN, LN_ONE), 32'h0);
    chk(exc_r, 1'b1);
    req(1'b1, pa(4'hD, 4'h3), 32'h0);
    chk(exc_r, 1'b1);
    chk(o_serial, 1'b1);
    gsr();
    req(1'b0, aa(16'h0000, XF_LOAD, LN_ONE), 32'h0);
    chk(exc_r, 1'b1);
    i_serial_dis = 1'b1;
    req(1'b1, pa(4'hD, 4'h3), 32'h0);
    chk(exc_r, 1'b0);
    i_serial_dis = 1'b0;
    gsr();
  endtask : t_refuse

  initial
  begin
    repeat (16) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clk);
    t_pass(4'hD);
    t_xfer();
    t_len(6'h03);
    t_len(6'h00);
    t_nop();
    t_refuse();
    i_assist_map = 16'h0000;
    t_pass(4'hC);
    end_of_test();
  end
endmodule : fpa_assist_seq_bench
